// file: output_enable_defines.svh
// Constants for the output enable and alarm control block
// Summary of operation
// - In analog remote mode only the standby pin switches the output on or off
// - A setting inverts the standby pin's meaning and its default request level
// - Open standby pin reads high; normal polarity then switches on when remote starts
// - Standby pin acts as an output lock also outside remote mode
// - Outside remote, output off, pin enabling: unlocked, button or command may switch on
// - Outside remote, output off, pin disabling: locked, switch-on refused with error
// - Outside remote, output on, pin enabling: stays on, commands switch off and on
// - Outside remote, pin to disabling turns output off; back to enabling turns on
// - While pin locks, button or command cancels the pending pin switch-on
// - Alarms switch output off; acknowledgement accepted only once cause is gone
// - Overtemperature and power-fail alarms clear themselves when cause disappears
// - Current at overcurrent threshold raises alarm and switches output off
// - Power at overpower threshold raises alarm; threshold from zero to 1.1 nominal
// - Overvoltage threshold defaults 103 percent, overcurrent and overpower 110 percent
// - AC supply out of specification raises power-fail alarm and switches output off
// - Internal temperature at limit raises overtemperature alarm and switches off
// - Protection thresholds change only while the output is off
// - Low remote-select pin enters analog remote; high or open keeps manual
// - Fault pin high while overtemperature or power-fail alarm present
`ifndef OUTPUT_ENABLE_DEFINES_SVH
`define OUTPUT_ENABLE_DEFINES_SVH
`define CLK_FREQ_HZ 125000000
`define ACK_LOW_MS 50
`define ACK_LOW_CYCLES ((`CLK_FREQ_HZ / 1000) * `ACK_LOW_MS)
`define THR_W 16
`define OV_DEFAULT_PCT 103
`define OC_DEFAULT_PCT 110
`define OP_DEFAULT_PCT 110
`define OP_MAX_PERMILLE 1100
`endif

// file: output_enable_pkg.sv
// Types for the output enable and alarm control block
package output_enable_pkg;
    typedef struct packed {
        logic overvoltage_protection;
        logic overcurrent_protection;
        logic overpower_protection;
        logic overtemperature_alarm;
        logic power_fail_alarm;
    } alarm_t;
    typedef struct packed {
        logic [15:0] ov_thr;
        logic [15:0] oc_thr;
        logic [15:0] op_thr;
    } thresholds_t;
endpackage : output_enable_pkg

// file: output_enable_alarm_control.sv
// Output enable lock and protection alarm control
`timescale 1ns/1ps
`include "output_enable_defines.svh"
module output_enable_alarm_control #(
    parameter int unsigned ACK_LOW_CYCLES = `ACK_LOW_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic output_standby_pin,
    input wire logic remote_select_pin,
    input wire logic standby_invert,
    input wire logic on_request,
    input wire logic off_request,
    input wire logic alarm_ack,
    input wire logic [15:0] nominal_voltage,
    input wire logic [15:0] nominal_current,
    input wire logic [15:0] nominal_power,
    input wire logic [15:0] meas_voltage,
    input wire logic [15:0] meas_current,
    input wire logic [15:0] meas_power,
    input wire logic temp_limit_hit,
    input wire logic ac_out_of_spec,
    input wire output_enable_pkg::thresholds_t thr_wr_data,
    input wire logic thr_wr,
    output logic output_on,
    output logic switch_on_error,
    output logic thr_wr_refused,
    output logic fault_pin,
    output logic overvoltage_pin,
    output logic remote_active,
    output output_enable_pkg::alarm_t alarms,
    output output_enable_pkg::thresholds_t thresholds
);
    import output_enable_pkg::*;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_ON = 3'b010,
        ST_PIN_LOCK = 3'b100
    } out_state_t;

    typedef struct packed {
        logic [1:0] sb_sync;
        logic [1:0] rem_sync;
        logic thr_init;
        out_state_t st;
        logic pend_on;
        logic [31:0] low_cnt;
        logic ack_ok;
        alarm_t alarm;
        thresholds_t thr;
        logic out_on;
        logic err;
        logic refused;
        logic fault;
        logic ov_flag;
        logic remote;
    } state_t;

    state_t q_ff;
    state_t nxt_q;

    // Percentage of a nominal value, kept to threshold width
    function automatic logic [15:0] pct_of(input logic [15:0] nom, input logic [7:0] pct);
        logic [31:0] p;
        p = (32'(nom) * 32'(pct)) / 32'd100;
        pct_of = p[15:0];
    endfunction : pct_of

    logic sb_level;
    logic sb_enable;
    logic remote_now;
    logic [31:0] op_max;
    logic any_alarm;
    logic latched_cause;

    // Synchronised pin levels and the polarity-resolved enable request
    always_comb begin
        sb_level = q_ff.sb_sync[1];
        sb_enable = sb_level ^ standby_invert;
        remote_now = ~q_ff.rem_sync[1];
        op_max = (32'(nominal_power) * 32'(`OP_MAX_PERMILLE)) / 32'd1000;
    end

    // Main next-state computation
    always_comb begin
        nxt_q = q_ff;
        any_alarm = 1'b0;
        latched_cause = 1'b0;
        nxt_q.err = 1'b0;
        nxt_q.refused = 1'b0;
        // Two flops per pin; only the second stage is read anywhere
        nxt_q.sb_sync = {q_ff.sb_sync[0], output_standby_pin};
        nxt_q.rem_sync = {q_ff.rem_sync[0], remote_select_pin};

        // Thresholds load their defaults once after reset, since nominals are ports
        if (!q_ff.thr_init) begin
            nxt_q.thr.ov_thr = pct_of(nominal_voltage, 8'(`OV_DEFAULT_PCT));
            nxt_q.thr.oc_thr = pct_of(nominal_current, 8'(`OC_DEFAULT_PCT));
            nxt_q.thr.op_thr = pct_of(nominal_power, 8'(`OP_DEFAULT_PCT));
            nxt_q.thr_init = 1'b1;
        end else if (thr_wr) begin
            if (q_ff.out_on) begin
                nxt_q.refused = 1'b1;
            end else begin
                nxt_q.thr = thr_wr_data;
                if (32'(thr_wr_data.op_thr) > op_max) begin
                    nxt_q.thr.op_thr = op_max[15:0];
                end
            end
        end

        // Hardware alarms follow their cause and need no acknowledgement
        nxt_q.alarm.overtemperature_alarm = temp_limit_hit;
        nxt_q.alarm.power_fail_alarm = ac_out_of_spec;

        // Remote acknowledgement: pin low long enough, then back high
        if (sb_level) begin
            nxt_q.low_cnt = '0;
        end else if (q_ff.low_cnt < ACK_LOW_CYCLES) begin
            nxt_q.low_cnt = q_ff.low_cnt + 32'd1;
        end
        nxt_q.ack_ok = (q_ff.low_cnt >= ACK_LOW_CYCLES);

        // Sticky protection alarms; cause test wins over acknowledge
        latched_cause = 1'b0;
        if (q_ff.thr_init && (meas_voltage >= q_ff.thr.ov_thr)) begin
            nxt_q.alarm.overvoltage_protection = 1'b1;
            latched_cause = 1'b1;
        end
        if (q_ff.thr_init && (meas_current >= q_ff.thr.oc_thr)) begin
            nxt_q.alarm.overcurrent_protection = 1'b1;
            latched_cause = 1'b1;
        end
        if (q_ff.thr_init && (meas_power >= q_ff.thr.op_thr)) begin
            nxt_q.alarm.overpower_protection = 1'b1;
            latched_cause = 1'b1;
        end
        if (!latched_cause && (alarm_ack || (q_ff.remote && sb_level && q_ff.ack_ok))) begin
            nxt_q.alarm.overvoltage_protection = 1'b0;
            nxt_q.alarm.overcurrent_protection = 1'b0;
            nxt_q.alarm.overpower_protection = 1'b0;
        end
        any_alarm = |nxt_q.alarm;

        // Output state machine
        if (remote_now) begin
            // Pin alone decides; buttons and commands are ignored
            nxt_q.st = sb_enable ? ST_ON : ST_OFF;
            nxt_q.pend_on = 1'b0;
        end else begin
            case (q_ff.st)
                ST_OFF: begin
                    if (on_request) begin
                        if (sb_enable) begin
                            nxt_q.st = ST_ON;
                        end else begin
                            nxt_q.err = 1'b1;
                        end
                    end
                end
                ST_ON: begin
                    if (!sb_enable) begin
                        nxt_q.st = ST_PIN_LOCK;
                        nxt_q.pend_on = 1'b1;
                    end else if (off_request) begin
                        nxt_q.st = ST_OFF;
                    end
                end
                ST_PIN_LOCK: begin
                    if (on_request || off_request) begin
                        nxt_q.pend_on = 1'b0;
                        if (on_request) begin
                            nxt_q.err = 1'b1;
                        end
                    end
                    if (sb_enable) begin
                        nxt_q.st = (q_ff.pend_on && !on_request && !off_request) ? ST_ON : ST_OFF;
                        nxt_q.pend_on = 1'b0;
                    end
                end
                default: begin
                    nxt_q.st = ST_OFF;
                end
            endcase
        end

        // Any alarm forces the output off and drops a pending pin request
        if (any_alarm) begin
            nxt_q.pend_on = 1'b0;
            if (remote_now) begin
                nxt_q.st = sb_enable ? q_ff.st : ST_OFF;
            end
            if (nxt_q.st == ST_ON) begin
                nxt_q.st = remote_now ? ST_ON : ST_OFF;
            end
        end
        nxt_q.out_on = (nxt_q.st == ST_ON) && !any_alarm;
        nxt_q.fault = nxt_q.alarm.overtemperature_alarm | nxt_q.alarm.power_fail_alarm;
        nxt_q.ov_flag = nxt_q.alarm.overvoltage_protection;
        nxt_q.remote = remote_now;
    end

    // State register; pins idle high so synchronisers reset high
    always_ff @(posedge clk) begin
        if (srst) begin
            q_ff <= '0;
            q_ff.sb_sync <= 2'b11;
            q_ff.rem_sync <= 2'b11;
            q_ff.st <= ST_OFF;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign output_on = q_ff.out_on;
    assign switch_on_error = q_ff.err;
    assign thr_wr_refused = q_ff.refused;
    assign fault_pin = q_ff.fault;
    assign overvoltage_pin = q_ff.ov_flag;
    assign remote_active = q_ff.remote;
    assign alarms = q_ff.alarm;
    assign thresholds = q_ff.thr;

    // Remote mode: output follows the synchronised pin enable on the next clock when no alarm
    AST_REMOTE_FOLLOWS_PIN: assert property (@(posedge clk) disable iff (srst)
        (remote_now && $stable(remote_now) && !any_alarm && sb_enable && $stable(sb_enable))
        |=> (output_on == 1'b1)) else $error("remote output does not follow standby pin");

    // A latched or live alarm and a lit output never coexist
    AST_ALARM_OFF: assert property (@(posedge clk) disable iff (srst)
        (|q_ff.alarm) |-> !output_on) else $error("output on while alarm active");

    // A locked switch-on gives an error pulse and leaves the output off
    AST_LOCK_REFUSE: assert property (@(posedge clk) disable iff (srst)
        (!remote_now && q_ff.st == ST_OFF && on_request && !sb_enable)
        |=> (switch_on_error && !output_on)) else $error("locked switch-on not refused");

    // An unlocked switch-on is taken on the next clock
    AST_UNLOCK_ON: assert property (@(posedge clk) disable iff (srst)
        (!remote_now && q_ff.st == ST_OFF && on_request && sb_enable && !any_alarm)
        |=> output_on) else $error("unlocked switch-on not taken");

    // A coincident alarm still moves the machine to ST_PIN_LOCK but drops the pending request, so it is excluded here
    sequence seq_pin_drop;
        !remote_now && q_ff.st == ST_ON && !sb_enable && !any_alarm;
    endsequence
    AST_PIN_DROP_OFF: assert property (@(posedge clk) disable iff (srst)
        seq_pin_drop |=> (q_ff.st == ST_PIN_LOCK && !output_on)) else $error("pin drop did not lock output");

    // Threshold writes while the output is on are refused and change nothing
    AST_THR_LOCKED: assert property (@(posedge clk) disable iff (srst)
        (q_ff.thr_init && thr_wr && q_ff.out_on) |=> (thr_wr_refused && $stable(thresholds)))
        else $error("threshold changed while output on");

    // Fault pin follows the hardware causes one clock late
    AST_FAULT_PIN: assert property (@(posedge clk) disable iff (srst)
        ##1 (fault_pin == ($past(temp_limit_hit) | $past(ac_out_of_spec))))
        else $error("fault pin mismatch");

    // Overcurrent trips on the clock after the threshold is reached
    AST_OC_TRIP: assert property (@(posedge clk) disable iff (srst)
        (q_ff.thr_init && meas_current >= q_ff.thr.oc_thr) |=> (alarms.overcurrent_protection && !output_on))
        else $error("overcurrent did not trip");

    AST_CANCEL_PEND: assert property (@(posedge clk) disable iff (srst)
        (!remote_now && q_ff.st == ST_PIN_LOCK && off_request) |=> !q_ff.pend_on)
        else $error("pending pin request not cancelled");

    // Overpower trips the same way as overcurrent
    AST_OP_TRIP: assert property (@(posedge clk) disable iff (srst)
        (q_ff.thr_init && meas_power >= q_ff.thr.op_thr) |=> (alarms.overpower_protection && !output_on))
        else $error("overpower did not trip");

    // Accepted overpower writes never exceed the clip limit
    AST_OP_CLIP: assert property (@(posedge clk) disable iff (srst)
        (q_ff.thr_init && thr_wr && !q_ff.out_on) |=> (32'(thresholds.op_thr) <= $past(op_max)))
        else $error("overpower threshold above limit");

    // Defaults are loaded on the first clock after reset from the nominals
    AST_DEFAULTS: assert property (@(posedge clk) disable iff (srst)
        !q_ff.thr_init
        |=> ((32'(thresholds.ov_thr) == (32'($past(nominal_voltage)) * 32'(`OV_DEFAULT_PCT)) / 32'd100)
            && (32'(thresholds.oc_thr) == (32'($past(nominal_current)) * 32'(`OC_DEFAULT_PCT)) / 32'd100)))
        else $error("default thresholds wrong");

    // Set wins over acknowledge: a live cause keeps the overvoltage alarm
    AST_OV_HELD: assert property (@(posedge clk) disable iff (srst)
        (q_ff.thr_init && meas_voltage >= q_ff.thr.ov_thr) |=> alarms.overvoltage_protection)
        else $error("overvoltage cleared while cause present");

    // Hardware alarms follow their cause and force the output off
    AST_PF_TRIP: assert property (@(posedge clk) disable iff (srst)
        ac_out_of_spec |=> (alarms.power_fail_alarm && !output_on))
        else $error("power fail did not trip");

    AST_OT_TRIP: assert property (@(posedge clk) disable iff (srst)
        temp_limit_hit |=> (alarms.overtemperature_alarm && !output_on))
        else $error("overtemperature did not trip");

    AST_SELF_CLEAR: assert property (@(posedge clk) disable iff (srst)
        (!temp_limit_hit && !ac_out_of_spec) |=> !(alarms.overtemperature_alarm || alarms.power_fail_alarm))
        else $error("hardware alarm did not clear itself");

    // In remote the disabling level keeps the output off whatever the commands say
    AST_REMOTE_OFF: assert property (@(posedge clk) disable iff (srst)
        (remote_now && !sb_enable) |=> !output_on)
        else $error("remote output on with pin disabling");

    // Remote flag is the inverted synchronised select level, one clock late
    AST_REMOTE_FLAG: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> (remote_active == $past(remote_now)))
        else $error("remote flag mismatch");

    // Entering remote with an open pin and normal polarity switches on at once
    sequence seq_remote_entry;
        remote_now && !q_ff.remote && sb_level && !standby_invert && !any_alarm;
    endsequence
    AST_OPEN_PIN_ON: assert property (@(posedge clk) disable iff (srst)
        seq_remote_entry |=> output_on) else $error("open pin did not switch on in remote");

    // Outside remote the disabling level keeps an idle output off
    AST_IDLE_LOCKED: assert property (@(posedge clk) disable iff (srst)
        (!remote_now && q_ff.st == ST_OFF && !sb_enable) |=> !output_on)
        else $error("locked idle output switched on");

    // Inverted polarity: a low pin unlocks an idle output
    AST_INVERT_UNLOCK: assert property (@(posedge clk) disable iff (srst)
        (!remote_now && q_ff.st == ST_OFF && on_request && standby_invert && !sb_level && !any_alarm)
        |=> output_on) else $error("inverted low pin did not unlock");

    // A running output with the pin enabling stays on without an off command
    AST_ON_HOLDS: assert property (@(posedge clk) disable iff (srst)
        (!remote_now && q_ff.st == ST_ON && sb_enable && !off_request && !any_alarm) |=> output_on)
        else $error("enabled output dropped");

    // Returning pin restores the output when no command cancelled the request
    sequence seq_pin_return;
        !remote_now && q_ff.st == ST_PIN_LOCK && q_ff.pend_on && sb_enable && !on_request && !off_request;
    endsequence
    AST_PIN_RETURN_ON: assert property (@(posedge clk) disable iff (srst)
        (seq_pin_return ##0 !any_alarm) |=> output_on) else $error("pin return did not switch on");

    // Pins pass exactly two flops; a shallower chain would risk metastable reads
    AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (srst)
        (!$past(srst) && !$past(srst, 2))
        |-> ((sb_level == $past(output_standby_pin, 2)) && (remote_now == !$past(remote_select_pin, 2))))
        else $error("pin synchroniser depth wrong");
endmodule : output_enable_alarm_control

// file: pin_ctrl_model.sv
// Model of the remote controller driving the standby and remote-select pins
`timescale 1ns/1ps
module pin_ctrl_model (
    input wire logic clk,
    output logic output_standby_pin,
    output logic remote_select_pin
);
    logic sb_drv = 1'b0;
    logic sb_lvl = 1'b0;
    logic rem_drv = 1'b0;
    // A released contact floats high through the pull-up, never holds its last level
    assign output_standby_pin = sb_drv ? sb_lvl : 1'b1;
    assign remote_select_pin = rem_drv ? 1'b0 : 1'b1;
    // Levels change on the falling edge, away from the sampling edge
    task automatic standby(input logic drv, input logic lvl);
        @(negedge clk);
        sb_drv = drv;
        sb_lvl = lvl;
    endtask : standby
    task automatic remote(input logic on);
        @(negedge clk);
        rem_drv = on;
    endtask : remote
    // Acknowledge: high, low for at least the minimum time, then high again
    task automatic ack_pulse(input int low_n);
        standby(1'b1, 1'b1);
        standby(1'b1, 1'b0);
        repeat (low_n) @(negedge clk);
        standby(1'b1, 1'b1);
    endtask : ack_pulse
endmodule : pin_ctrl_model

// file: testbench.sv
// Self-checking bench for the output enable and alarm control block
`timescale 1ns/1ps
module testbench;
    import output_enable_pkg::*;
    localparam int unsigned ACK_N = 20;
    logic clk = 1'b0;
    logic srst, sb_pin, rem_pin, inv, on_rq, off_rq, ack, t_hit, ac_bad, thr_wr;
    logic [15:0] m_v, m_i, m_p;
    thresholds_t wr_data, thr;
    logic out_on, on_err, wr_ref, fault, ov_out, rem_act;
    alarm_t alm;
    int failures = 0;
    int check_count = 0;
    int err_n = 0;
    int ref_n = 0;
    int cycles = 0;
    int e;
    output_enable_alarm_control #(.ACK_LOW_CYCLES(ACK_N)) dut (.clk(clk), .srst(srst),
        .output_standby_pin(sb_pin), .remote_select_pin(rem_pin), .standby_invert(inv),
        .on_request(on_rq), .off_request(off_rq), .alarm_ack(ack), .nominal_voltage(16'h03e8),
        .nominal_current(16'h0064), .nominal_power(16'h07d0), .meas_voltage(m_v),
        .meas_current(m_i), .meas_power(m_p), .temp_limit_hit(t_hit), .ac_out_of_spec(ac_bad),
        .thr_wr_data(wr_data), .thr_wr(thr_wr), .output_on(out_on), .switch_on_error(on_err),
        .thr_wr_refused(wr_ref), .fault_pin(fault), .overvoltage_pin(ov_out), .remote_active(rem_act),
        .alarms(alm), .thresholds(thr));
    pin_ctrl_model ctl (.clk(clk), .output_standby_pin(sb_pin), .remote_select_pin(rem_pin));
    initial begin
        forever #4 clk = ~clk;
    end
    // Pulses are counted here so a one-cycle answer is never missed; also the hang limit
    always @(posedge clk) begin
        cycles++;
        if (on_err === 1'b1) err_n++;
        if (wr_ref === 1'b1) ref_n++;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
        cyc(1);
    endtask : pulse
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // Pin low locks an idle output; releasing it must not switch on by itself
    task automatic t_lock();
        ctl.standby(1'b1, 1'b0);
        cyc(5);
        e = err_n;
        pulse(on_rq);
        check(out_on, 1'b0);
        check(err_n - e, 1);
        ctl.standby(1'b0, 1'b0);
        cyc(5);
        check(out_on, 1'b0);
    endtask : t_lock
    // Commands work while unlocked; pin toggling switches off and back on
    task automatic t_manual();
        pulse(on_rq);
        check(out_on, 1'b1);
        pulse(off_rq);
        check(out_on, 1'b0);
        pulse(on_rq);
        ctl.standby(1'b1, 1'b0);
        cyc(5);
        check(out_on, 1'b0);
        ctl.standby(1'b1, 1'b1);
        cyc(5);
        check(out_on, 1'b1);
        ctl.standby(1'b1, 1'b0);
        cyc(5);
        pulse(off_rq);
        ctl.standby(1'b0, 1'b0);
        cyc(5);
        check(out_on, 1'b0);
    endtask : t_manual
    // Inverted polarity: open pin locks, low pin unlocks
    task automatic t_invert();
        inv = 1'b1;
        cyc(5);
        e = err_n;
        pulse(on_rq);
        check(err_n - e, 1);
        ctl.standby(1'b1, 1'b0);
        cyc(5);
        pulse(on_rq);
        check(out_on, 1'b1);
        pulse(off_rq);
        ctl.standby(1'b0, 1'b0);
        inv = 1'b0;
        cyc(5);
    endtask : t_invert
    // Remote: open pin switches on, commands ignored, alarm cleared by pin acknowledge
    task automatic t_remote();
        ctl.remote(1'b1);
        cyc(5);
        check(rem_act, 1'b1);
        check(out_on, 1'b1);
        pulse(off_rq);
        check(out_on, 1'b1);
        m_i = 16'h006e;
        cyc(3);
        check(alm.overcurrent_protection, 1'b1);
        check(out_on, 1'b0);
        m_i = 16'h0000;
        ctl.ack_pulse(ACK_N + 5);
        cyc(5);
        check(alm, 5'h00);
        check(out_on, 1'b1);
        ctl.standby(1'b1, 1'b0);
        cyc(5);
        check(out_on, 1'b0);
        ctl.remote(1'b0);
        ctl.standby(1'b0, 1'b0);
        cyc(5);
    endtask : t_remote
    // Overvoltage needs acknowledge after the cause; hardware alarms clear themselves
    task automatic t_alarms();
        pulse(on_rq);
        m_v = 16'h0405;
        cyc(3);
        check(out_on, 1'b1);
        m_v = 16'h0406;
        cyc(3);
        check({ov_out, alm.overvoltage_protection, out_on}, 3'b110);
        pulse(ack);
        check(alm.overvoltage_protection, 1'b1);
        m_v = 16'h0000;
        pulse(ack);
        check(alm, 5'h00);
        for (int k = 1; k <= 2; k++) begin
            pulse(on_rq);
            {t_hit, ac_bad} = 2'(k);
            cyc(3);
            check({fault, out_on, alm}, {2'b10, 3'b000, 2'(k)});
            {t_hit, ac_bad} = 2'b00;
            cyc(3);
            check({fault, alm}, 6'h00);
        end
    endtask : t_alarms
    // Threshold writes: overpower clipped, refused while on; overpower trip
    task automatic t_thr();
        wr_data = {16'h0400, 16'h0050, 16'hffff};
        pulse(thr_wr);
        check(thr, {16'h0400, 16'h0050, 16'h0898});
        pulse(on_rq);
        e = ref_n;
        wr_data = '0;
        pulse(thr_wr);
        check(ref_n - e, 1);
        check(thr, {16'h0400, 16'h0050, 16'h0898});
        m_p = 16'h0898;
        cyc(3);
        check({alm.overpower_protection, out_on}, 2'b10);
    endtask : t_thr
    initial begin
        srst = 1'b1;
        {inv, on_rq, off_rq, ack, t_hit, ac_bad, thr_wr} = '0;
        {m_v, m_i, m_p} = '0;
        wr_data = '0;
        cyc(16);
        srst = 1'b0;
        cyc(3);
        check(thr, {16'h0406, 16'h006e, 16'h0898});
        t_lock();
        t_manual();
        t_invert();
        t_remote();
        t_alarms();
        t_thr();
        end_sim();
    end
endmodule : testbench
